// ===== uart_ctrl_pkg.sv
`default_nettype none
package uart_ctrl_pkg;
    // ------------------------------------------------------------
    // register offsets on the byte-wide port
    // ------------------------------------------------------------
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_IER = 3'h1;
    localparam logic [2:0] OFS_IIR = 3'h2;
    localparam logic [2:0] OFS_LCR = 3'h3;
    localparam logic [2:0] OFS_MCR = 3'h4;
    localparam logic [2:0] OFS_LSR = 3'h5;
    localparam logic [2:0] OFS_MSR = 3'h6;
    localparam logic [2:0] OFS_SCR = 3'h7;
    // ------------------------------------------------------------
    // field layouts and reset values
    // ------------------------------------------------------------
    localparam int IER_RDA = 0;
    localparam int IER_THRE = 1;
    localparam int IER_LSI = 2;
    localparam int IER_MSI = 3;
    localparam logic [7:0] IER_WMASK = 8'h0f;
    localparam logic [7:0] MCR_WMASK = 8'h1f;
    localparam logic [7:0] LCR_RST = 8'h00;
    localparam logic [7:0] MCR_RST = 8'h00;
    localparam int FCR_EN_BIT = 0;
    localparam int FCR_TRIG_LSB = 6;
    localparam int FCR_TRIG_MSB = 7;
    // identification codes, low nibble
    localparam logic [3:0] IIR_NONE = 4'h1;
    localparam logic [3:0] IIR_LSI = 4'h6;
    localparam logic [3:0] IIR_RDA = 4'h4;
    localparam logic [3:0] IIR_TO = 4'hc;
    localparam logic [3:0] IIR_THRE = 4'h2;
    localparam logic [3:0] IIR_MSI = 4'h0;
    // receive trigger levels in bytes
    localparam logic [4:0] TRIG_L0 = 5'h01;
    localparam logic [4:0] TRIG_L1 = 5'h04;
    localparam logic [4:0] TRIG_L2 = 5'h08;
    localparam logic [4:0] TRIG_L3 = 5'h0e;
    // idle character times before a timeout
    localparam logic [2:0] TIMEOUT_CHARS = 3'h4;
    // data masks per word length
    localparam logic [1:0] WLEN_5 = 2'h0;
    localparam logic [7:0] WMASK_5 = 8'h1f;
    localparam logic [7:0] WMASK_6 = 8'h3f;
    localparam logic [7:0] WMASK_7 = 8'h7f;
    localparam logic [7:0] WMASK_8 = 8'hff;
    // stop length in half bit times
    localparam logic [2:0] STOP_ONE_H = 3'h2;
    localparam logic [2:0] STOP_ONEHALF_H = 3'h3;
    localparam logic [2:0] STOP_TWO_H = 3'h4;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic divisor_latch_access;
        logic brk;
        logic stick;
        logic even;
        logic par_en;
        logic stop;
        logic [1:0] wlen;
    } line_fmt_t;
    typedef struct packed {
        logic [2:0] rsvd;
        logic loop;
        logic interrupt_gate_bit;
        logic user_output_bit_one;
        logic rts;
        logic dtr;
    } modem_ctl_t;
    typedef struct packed {
        logic done;
        logic [7:0] data;
        logic par;
        logic stop1;
    } rx_evt_t;
endpackage : uart_ctrl_pkg
`default_nettype wire

// ===== uart_irq_line_modem_ctrl.sv
// Summary of operation
// - ident low nibble 0001 idle; priority codes 6,4,C,2,0 highest first
// - fifo mode: timeout after four idle char times with data; buffer read clears
// - transmit-empty cleared by ident read while reported, or holding write
// - format bits 1:0 pick 5 to 8 data bits
// - bit 2 gives 1.5 stops for 5 bits, else 2 stops
// - receiver checks only the first stop bit
// - bit 3 adds parity after data, checked on receive
// - bit 4 clear odd parity, set even parity
// - stick bit 5 forces parity to inverse of bit 4
// - bit 6 holds serial output low while set
// - bit 7 maps divisor latches at offsets 0 and 1
// - modem bit 0 drives terminal ready pin inverted
// - modem bit 1 drives request to send pin inverted
// - modem bit 2 is plain storage, no pin
// - modem bit 3 gates interrupt output, else high impedance
// - enable bits 0..3 gate four sources, bits 4..7 read zero
// - trigger codes give 1, 4, 8 or 14 bytes
// - ident code frozen during its read access
`timescale 1ns/1ps
`default_nettype none
module uart_irq_line_modem_ctrl #(
    parameter int LVL_W = 5
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic [7:0] rbr_data_i,
    input wire logic [7:0] lsr_data_i,
    input wire logic [7:0] msr_data_i,
    input wire logic line_err_i,
    input wire logic modem_delta_i,
    input wire logic thr_empty_i,
    input wire logic rx_push_i,
    input wire logic [LVL_W-1:0] rx_level_i,
    input wire logic char_tick_i,
    input wire uart_ctrl_pkg::rx_evt_t rx_evt_i,
    input wire logic [7:0] tx_data_i,
    input wire logic txd_i,
    output logic rbr_rd_o,
    output logic thr_wr_o,
    output logic [7:0] thr_data_o,
    output logic lsr_rd_o,
    output logic msr_rd_o,
    output logic fifo_en_o,
    output logic [15:0] divisor_o,
    output uart_ctrl_pkg::line_fmt_t line_fmt_o,
    output logic [2:0] stop_half_o,
    output logic tx_par_o,
    output logic rx_par_err_o,
    output logic rx_frame_err_o,
    output logic txd_o,
    output logic terminal_ready_n_o,
    output logic request_to_send_n_o,
    output logic irq_o,
    output logic irq_oe_o
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [LVL_W-1:0] trig_level(input logic [1:0] code);
        logic [4:0] t;
        unique case (code)
            2'h0: t = uart_ctrl_pkg::TRIG_L0;
            2'h1: t = uart_ctrl_pkg::TRIG_L1;
            2'h2: t = uart_ctrl_pkg::TRIG_L2;
            2'h3: t = uart_ctrl_pkg::TRIG_L3;
        endcase
        return LVL_W'(t);
    endfunction : trig_level

    // parity bit for the data bits in use, shared by both directions
    function automatic logic par_bit(input logic [7:0] d, input uart_ctrl_pkg::line_fmt_t f);
        logic [7:0] m;
        unique case (f.wlen)
            2'h0: m = uart_ctrl_pkg::WMASK_5;
            2'h1: m = uart_ctrl_pkg::WMASK_6;
            2'h2: m = uart_ctrl_pkg::WMASK_7;
            2'h3: m = uart_ctrl_pkg::WMASK_8;
        endcase
        if (f.stick)
        begin
            return ~f.even;
        end
        return f.even ? ^(d & m) : ~^(d & m);
    endfunction : par_bit

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    uart_ctrl_pkg::line_fmt_t lcr_r, lcr_nxt;
    uart_ctrl_pkg::modem_ctl_t mcr_r, mcr_nxt;
    logic [7:0] ier_r, ier_nxt, dll_r, dll_nxt, dlm_r, dlm_nxt;
    logic [7:0] rdata_nxt, thr_data_nxt;
    logic [1:0] trig_r, trig_nxt;
    logic fifo_en_nxt, rbr_rd_nxt, thr_wr_nxt, lsr_rd_nxt, msr_rd_nxt;
    logic lsi_r, lsi_nxt, thre_r, thre_nxt, msi_r, msi_nxt, to_r, to_nxt;
    logic [2:0] to_cnt_r, to_cnt_nxt, stop_half_nxt;
    logic irq_nxt, irq_oe_nxt, txd_nxt, tx_par_nxt, perr_nxt, ferr_nxt;
    logic [3:0] iir_code;
    logic pend_any, rda_lvl;
    logic rbr_read, iir_read, lsr_read, msr_read, thr_write, line_evt;

    // decoded host accesses
    always_comb
    begin
        rbr_read = rd_i && addr_i == uart_ctrl_pkg::OFS_DATA && !lcr_r.divisor_latch_access;
        thr_write = wr_i && addr_i == uart_ctrl_pkg::OFS_DATA && !lcr_r.divisor_latch_access;
        iir_read = rd_i && addr_i == uart_ctrl_pkg::OFS_IIR;
        lsr_read = rd_i && addr_i == uart_ctrl_pkg::OFS_LSR;
        msr_read = rd_i && addr_i == uart_ctrl_pkg::OFS_MSR;
    end

    // ------------------------------------------------------------
    // interrupt priority
    // ------------------------------------------------------------
    // data-available is a level so it drops by itself once the fifo drains below trigger
    always_comb
    begin
        rda_lvl = fifo_en_o ? (rx_level_i >= trig_level(trig_r)) : (rx_level_i != '0);
        iir_code = uart_ctrl_pkg::IIR_NONE;
        if (lsi_r && ier_r[uart_ctrl_pkg::IER_LSI])
            iir_code = uart_ctrl_pkg::IIR_LSI;
        else if (rda_lvl && ier_r[uart_ctrl_pkg::IER_RDA])
            iir_code = uart_ctrl_pkg::IIR_RDA;
        else if (to_r && ier_r[uart_ctrl_pkg::IER_RDA])
            iir_code = uart_ctrl_pkg::IIR_TO;
        else if (thre_r && ier_r[uart_ctrl_pkg::IER_THRE])
            iir_code = uart_ctrl_pkg::IIR_THRE;
        else if (msi_r && ier_r[uart_ctrl_pkg::IER_MSI])
            iir_code = uart_ctrl_pkg::IIR_MSI;
        pend_any = iir_code != uart_ctrl_pkg::IIR_NONE;
    end

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    // read data is sampled once at the strobe, so a code seen by the host cannot shift under it
    always_comb
    begin
        lcr_nxt = lcr_r;
        mcr_nxt = mcr_r;
        ier_nxt = ier_r;
        dll_nxt = dll_r;
        dlm_nxt = dlm_r;
        trig_nxt = trig_r;
        fifo_en_nxt = fifo_en_o;
        thr_data_nxt = thr_data_o;
        thr_wr_nxt = 1'b0;
        rbr_rd_nxt = 1'b0;
        lsr_rd_nxt = lsr_read;
        msr_rd_nxt = msr_read;
        rdata_nxt = 8'h00;
        if (wr_i)
        begin
            case (addr_i)
                uart_ctrl_pkg::OFS_DATA:
                    if (lcr_r.divisor_latch_access)
                        dll_nxt = wdata_i;
                    else
                    begin
                        thr_wr_nxt = 1'b1;
                        thr_data_nxt = wdata_i;
                    end
                uart_ctrl_pkg::OFS_IER:
                    if (lcr_r.divisor_latch_access)
                        dlm_nxt = wdata_i;
                    else
                        ier_nxt = wdata_i & uart_ctrl_pkg::IER_WMASK;
                uart_ctrl_pkg::OFS_IIR:
                begin
                    // trigger only takes when the enable bit is written as one
                    fifo_en_nxt = wdata_i[uart_ctrl_pkg::FCR_EN_BIT];
                    if (wdata_i[uart_ctrl_pkg::FCR_EN_BIT])
                        trig_nxt = wdata_i[uart_ctrl_pkg::FCR_TRIG_MSB:uart_ctrl_pkg::FCR_TRIG_LSB];
                end
                uart_ctrl_pkg::OFS_LCR: lcr_nxt = uart_ctrl_pkg::line_fmt_t'(wdata_i);
                uart_ctrl_pkg::OFS_MCR: mcr_nxt = uart_ctrl_pkg::modem_ctl_t'(wdata_i & uart_ctrl_pkg::MCR_WMASK);
                uart_ctrl_pkg::OFS_LSR, uart_ctrl_pkg::OFS_MSR, uart_ctrl_pkg::OFS_SCR: ;
            endcase
        end
        if (rd_i)
        begin
            case (addr_i)
                uart_ctrl_pkg::OFS_DATA:
                    if (lcr_r.divisor_latch_access)
                        rdata_nxt = dll_r;
                    else
                    begin
                        rdata_nxt = rbr_data_i;
                        rbr_rd_nxt = 1'b1;
                    end
                uart_ctrl_pkg::OFS_IER: rdata_nxt = lcr_r.divisor_latch_access ? dlm_r : ier_r;
                uart_ctrl_pkg::OFS_IIR: rdata_nxt = {fifo_en_o, fifo_en_o, 2'b00, iir_code};
                uart_ctrl_pkg::OFS_LCR: rdata_nxt = lcr_r;
                uart_ctrl_pkg::OFS_MCR: rdata_nxt = mcr_r;
                uart_ctrl_pkg::OFS_LSR: rdata_nxt = lsr_data_i;
                uart_ctrl_pkg::OFS_MSR: rdata_nxt = msr_data_i;
                uart_ctrl_pkg::OFS_SCR: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            lcr_r <= uart_ctrl_pkg::line_fmt_t'(uart_ctrl_pkg::LCR_RST);
            mcr_r <= uart_ctrl_pkg::modem_ctl_t'(uart_ctrl_pkg::MCR_RST);
            ier_r <= 8'h00;
            dll_r <= 8'h00;
            dlm_r <= 8'h00;
            trig_r <= 2'h0;
            fifo_en_o <= 1'b0;
            thr_data_o <= 8'h00;
            thr_wr_o <= 1'b0;
            rbr_rd_o <= 1'b0;
            lsr_rd_o <= 1'b0;
            msr_rd_o <= 1'b0;
            rdata_o <= 8'h00;
        end
        else
        begin
            lcr_r <= lcr_nxt;
            mcr_r <= mcr_nxt;
            ier_r <= ier_nxt;
            dll_r <= dll_nxt;
            dlm_r <= dlm_nxt;
            trig_r <= trig_nxt;
            fifo_en_o <= fifo_en_nxt;
            thr_data_o <= thr_data_nxt;
            thr_wr_o <= thr_wr_nxt;
            rbr_rd_o <= rbr_rd_nxt;
            lsr_rd_o <= lsr_rd_nxt;
            msr_rd_o <= msr_rd_nxt;
            rdata_o <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // interrupt sources and line side
    // ------------------------------------------------------------
    // every sticky source but the timeout lets a same-cycle event win over its clear
    always_comb
    begin
        perr_nxt = rx_par_err_o;
        ferr_nxt = rx_frame_err_o;
        if (rx_evt_i.done)
        begin
            perr_nxt = lcr_r.par_en && (rx_evt_i.par != par_bit(rx_evt_i.data, lcr_r));
            ferr_nxt = !rx_evt_i.stop1;
        end
        line_evt = line_err_i || (rx_evt_i.done && (perr_nxt || ferr_nxt));
        lsi_nxt = line_evt || (lsi_r && !lsr_read);
        msi_nxt = modem_delta_i || (msi_r && !msr_read);
        thre_nxt = thr_empty_i || (thre_r && !thr_write && !(iir_read && iir_code == uart_ctrl_pkg::IIR_THRE));
        // any fifo movement restarts the idle count; a buffer read is such movement
        if (!fifo_en_o || rx_level_i == '0 || rx_push_i || rbr_read)
        begin
            to_cnt_nxt = 3'h0;
            to_nxt = 1'b0;
        end
        else
        begin
            to_cnt_nxt = (char_tick_i && to_cnt_r != uart_ctrl_pkg::TIMEOUT_CHARS) ? to_cnt_r + 3'h1 : to_cnt_r;
            to_nxt = to_r || to_cnt_nxt == uart_ctrl_pkg::TIMEOUT_CHARS;
        end
        irq_nxt = pend_any && mcr_r.interrupt_gate_bit;
        irq_oe_nxt = mcr_r.interrupt_gate_bit;
        txd_nxt = lcr_r.brk ? 1'b0 : txd_i;
        tx_par_nxt = lcr_r.par_en && par_bit(tx_data_i, lcr_r);
        if (!lcr_r.stop)
            stop_half_nxt = uart_ctrl_pkg::STOP_ONE_H;
        else if (lcr_r.wlen == uart_ctrl_pkg::WLEN_5)
            stop_half_nxt = uart_ctrl_pkg::STOP_ONEHALF_H;
        else
            stop_half_nxt = uart_ctrl_pkg::STOP_TWO_H;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            lsi_r <= 1'b0;
            msi_r <= 1'b0;
            thre_r <= 1'b0;
            to_r <= 1'b0;
            to_cnt_r <= 3'h0;
            irq_o <= 1'b0;
            irq_oe_o <= 1'b0;
            txd_o <= 1'b1;
            tx_par_o <= 1'b0;
            rx_par_err_o <= 1'b0;
            rx_frame_err_o <= 1'b0;
            stop_half_o <= uart_ctrl_pkg::STOP_ONE_H;
            line_fmt_o <= uart_ctrl_pkg::line_fmt_t'(uart_ctrl_pkg::LCR_RST);
            divisor_o <= 16'h0000;
            terminal_ready_n_o <= 1'b1;
            request_to_send_n_o <= 1'b1;
        end
        else
        begin
            lsi_r <= lsi_nxt;
            msi_r <= msi_nxt;
            thre_r <= thre_nxt;
            to_r <= to_nxt;
            to_cnt_r <= to_cnt_nxt;
            irq_o <= irq_nxt;
            irq_oe_o <= irq_oe_nxt;
            txd_o <= txd_nxt;
            tx_par_o <= tx_par_nxt;
            rx_par_err_o <= perr_nxt;
            rx_frame_err_o <= ferr_nxt;
            stop_half_o <= stop_half_nxt;
            line_fmt_o <= lcr_r;
            divisor_o <= {dlm_r, dll_r};
            terminal_ready_n_o <= !mcr_r.dtr;
            request_to_send_n_o <= !mcr_r.rts;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    AST_IIR_IDLE: assert property (iir_read && !pend_any |=> rdata_o[3:0] == 4'h1)
        else $error("idle ident code wrong");
    AST_IIR_LSI: assert property (iir_read && lsi_r && ier_r[2] |=> rdata_o[3:0] == 4'h6)
        else $error("line status not reported first");
    AST_TO_MODE: assert property (to_r |-> $past(fifo_en_o && rx_level_i != '0))
        else $error("timeout outside fifo mode");
    AST_THRE_CLR: assert property (thr_write && !thr_empty_i |=> !thre_r)
        else $error("holding write did not clear empty");
    AST_STOP: assert property (lcr_r.stop && lcr_r.wlen == 2'h0 && $stable(lcr_r) |=> stop_half_o == 3'h3)
        else $error("stop length wrong");
    AST_STICK: assert property (lcr_r.par_en && lcr_r.stick |=> tx_par_o == !$past(lcr_r.even))
        else $error("stick parity wrong");
    AST_BREAK: assert property (lcr_r.brk |=> !txd_o)
        else $error("break not holding line low");
    AST_DTR: assert property (##1 terminal_ready_n_o == !$past(mcr_r.dtr))
        else $error("terminal ready pin wrong");
    AST_RTS: assert property (mcr_r.rts |=> !request_to_send_n_o)
        else $error("request to send pin wrong");
    AST_GATE: assert property (!mcr_r.interrupt_gate_bit |=> !irq_o && !irq_oe_o)
        else $error("interrupt not gated");
    AST_IER_HI: assert property (rd_i && addr_i == 3'h1 && !lcr_r.divisor_latch_access |=> rdata_o[7:4] == 4'h0)
        else $error("enable upper bits not zero");
    AST_IRQ: assert property (pend_any && mcr_r.interrupt_gate_bit |=> irq_o)
        else $error("pending interrupt not asserted");
    AST_LSI_CLR: assert property (lsr_read && !line_err_i && !rx_evt_i.done |=> !lsi_r)
        else $error("line status read did not clear");

    COV_TIMEOUT: cover property (!to_r ##1 to_r);
    COV_THRE_IIR: cover property (iir_read && iir_code == 4'h2);
    COV_BREAK: cover property (lcr_r.brk ##1 !lcr_r.brk);
    COV_IRQ: cover property (!irq_o ##1 irq_o);
endmodule : uart_irq_line_modem_ctrl
`default_nettype wire

// ===== modem_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// modem peer: answers terminal ready with a set-ready change
// ------------------------------------------------------------
module modem_peer_model (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic terminal_ready_n_i,
    input wire logic msr_rd_i,
    output logic modem_delta_o,
    output logic [7:0] msr_data_o
);
    logic ready_n_r;
    logic [1:0] wait_r;
    // the peer needs a few cycles to raise set-ready, so the delta is late
    always @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ready_n_r <= 1'b1;
            wait_r <= 2'h0;
            modem_delta_o <= 1'b0;
            msr_data_o <= 8'h00;
        end
        else
        begin
            ready_n_r <= terminal_ready_n_i;
            modem_delta_o <= (wait_r == 2'h1);
            if (ready_n_r && !terminal_ready_n_i)
                wait_r <= 2'h3;
            else if (wait_r != 2'h0)
                wait_r <= wait_r - 2'h1;
            if (wait_r == 2'h1)
                msr_data_o <= 8'h22;
            else if (msr_rd_i)
                msr_data_o <= msr_data_o & 8'hf0; // delta bits clear on status read
        end
    end
endmodule : modem_peer_model
`default_nettype wire

// ===== tb_uart_irq_line_modem_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_uart_irq_line_modem_ctrl;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [2:0] ev = 3'h0;
    logic [4:0] level = 5'h00;
    uart_ctrl_pkg::rx_evt_t rx_evt = '0;
    logic [7:0] tx_data = 8'h00;
    logic txd = 1'b1;
    wire logic [7:0] rdata, thr_data, msr_data;
    wire logic rbr_rd, thr_wr, lsr_rd, msr_rd, fifo_en, tx_par, par_err, frame_err, txd_o;
    wire logic dtr_n, rts_n, irq, irq_oe, mdelta;
    wire logic [15:0] divisor;
    wire logic [2:0] stop_half;
    wire uart_ctrl_pkg::line_fmt_t line_fmt;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    uart_irq_line_modem_ctrl #(.LVL_W(5)) i_uart_irq_line_modem_ctrl (.mclk_i(mclk), .rst_n_i(rst_n),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .rbr_data_i(8'ha5),
        .lsr_data_i(8'h60), .msr_data_i(msr_data), .line_err_i(ev[0]), .modem_delta_i(mdelta),
        .thr_empty_i(ev[1]), .rx_push_i(1'b0), .rx_level_i(level), .char_tick_i(ev[2]), .rx_evt_i(rx_evt),
        .tx_data_i(tx_data), .txd_i(txd), .rbr_rd_o(rbr_rd), .thr_wr_o(thr_wr), .thr_data_o(thr_data),
        .lsr_rd_o(lsr_rd), .msr_rd_o(msr_rd), .fifo_en_o(fifo_en), .divisor_o(divisor),
        .line_fmt_o(line_fmt), .stop_half_o(stop_half), .tx_par_o(tx_par), .rx_par_err_o(par_err),
        .rx_frame_err_o(frame_err), .txd_o(txd_o), .terminal_ready_n_o(dtr_n),
        .request_to_send_n_o(rts_n), .irq_o(irq), .irq_oe_o(irq_oe));
    modem_peer_model i_modem_peer_model (.mclk_i(mclk), .rst_n_i(rst_n), .terminal_ready_n_i(dtr_n),
        .msr_rd_i(msr_rd), .modem_delta_o(mdelta), .msr_data_o(msr_data));
    // ------------------------------------------------------------
    // clock, run limit and bus helpers
    // ------------------------------------------------------------
    always #10 mclk = ~mclk;
    // the whole run needs well under a thousand cycles
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_fail++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg
    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 `CHK(rdata, e)
    endtask : rd_chk
    task automatic settle();
        repeat (2) @(posedge mclk);
        #1;
    endtask : settle
    // bit 0 line error, bit 1 holding empty, bit 2 character time
    task automatic pulse(input logic [2:0] m);
        @(posedge mclk);
        ev <= m;
        @(posedge mclk);
        ev <= 3'h0;
    endtask : pulse
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_modem();
        wr_reg(uart_ctrl_pkg::OFS_MCR, 8'hff);
        settle();
        `CHK({dtr_n, rts_n, irq_oe}, 3'h1)
        rd_chk(uart_ctrl_pkg::OFS_MCR, 8'h1f);
        repeat (6) @(posedge mclk);
        rd_chk(uart_ctrl_pkg::OFS_MSR, 8'h22);
        rd_chk(uart_ctrl_pkg::OFS_MSR, 8'h20);
        wr_reg(uart_ctrl_pkg::OFS_MCR, 8'h04);
        settle();
        `CHK({dtr_n, rts_n, irq_oe}, 3'h6)
        rd_chk(uart_ctrl_pkg::OFS_MCR, 8'h04);
    endtask : t_modem
    task automatic t_format();
        logic [7:0] lc [6] = '{8'h08, 8'h0b, 8'h1b, 8'h3b, 8'h2b, 8'h03};
        logic [7:0] dt [6] = '{8'he3, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03};
        logic ex [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
        for (int c = 0; c < 4; c++)
        begin
            wr_reg(uart_ctrl_pkg::OFS_LCR, 8'h04 | 8'(c));
            settle();
            `CHK(line_fmt.wlen, 2'(c))
            `CHK(stop_half, (c == 0) ? 3'h3 : 3'h4)
        end
        for (int i = 0; i < 6; i++)
        begin
            tx_data <= dt[i];
            wr_reg(uart_ctrl_pkg::OFS_LCR, lc[i]);
            settle();
            `CHK(tx_par, ex[i])
        end
        `CHK(stop_half, 3'h2)
    endtask : t_format
    task automatic t_receive(input logic p, input logic s, input logic [1:0] e);
        @(posedge mclk);
        rx_evt <= {1'b1, 8'h03, p, s};
        @(posedge mclk);
        rx_evt <= '0;
        settle();
        `CHK({par_err, frame_err}, e)
    endtask : t_receive
    task automatic t_break_divisor_latch_access();
        wr_reg(uart_ctrl_pkg::OFS_LCR, 8'h43);
        settle();
        `CHK(txd_o, 1'b0)
        wr_reg(uart_ctrl_pkg::OFS_LCR, 8'h83);
        wr_reg(3'h0, 8'h34);
        wr_reg(3'h1, 8'h12);
        settle();
        `CHK({txd_o, divisor}, 17'h11234)
        rd_chk(3'h0, 8'h34);
        wr_reg(uart_ctrl_pkg::OFS_LCR, 8'h03);
        wr_reg(uart_ctrl_pkg::OFS_IER, 8'hff);
        rd_chk(uart_ctrl_pkg::OFS_IER, 8'h0f);
        wr_reg(3'h0, 8'h5a);
        #1 `CHK({thr_wr, thr_data}, 9'h15a)
        rd_chk(3'h0, 8'ha5);
        `CHK(rbr_rd, 1'b1)
    endtask : t_break_divisor_latch_access
    task automatic t_irq();
        wr_reg(uart_ctrl_pkg::OFS_MCR, 8'h08);
        pulse(3'h2);
        settle();
        `CHK({irq, irq_oe}, 2'h3)
        rd_chk(uart_ctrl_pkg::OFS_IIR, 8'h02);
        rd_chk(uart_ctrl_pkg::OFS_IIR, 8'h01);
        pulse(3'h2);
        pulse(3'h1);
        settle();
        rd_chk(uart_ctrl_pkg::OFS_IIR, 8'h06);
        rd_chk(uart_ctrl_pkg::OFS_LSR, 8'h60);
        settle();
        rd_chk(uart_ctrl_pkg::OFS_IIR, 8'h02);
        pulse(3'h2);
        wr_reg(3'h0, 8'h11);
        settle();
        rd_chk(uart_ctrl_pkg::OFS_IIR, 8'h01);
        `CHK(irq, 1'b0)
        wr_reg(uart_ctrl_pkg::OFS_MCR, 8'h09);
        repeat (6) @(posedge mclk);
        rd_chk(uart_ctrl_pkg::OFS_IIR, 8'h00);
        wr_reg(uart_ctrl_pkg::OFS_MCR, 8'h01);
        settle();
        `CHK(irq_oe, 1'b0)
        rd_chk(uart_ctrl_pkg::OFS_MSR, 8'h22);
        level <= 5'h01;
        settle();
        rd_chk(uart_ctrl_pkg::OFS_IIR, 8'h04);
    endtask : t_irq
    task automatic t_fifo();
        logic [4:0] trig [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
        for (int c = 0; c < 4; c++)
        begin
            wr_reg(uart_ctrl_pkg::OFS_IIR, {2'(c), 6'h01});
            level <= trig[c] - 5'h01;
            settle();
            rd_chk(uart_ctrl_pkg::OFS_IIR, 8'hc1);
            level <= trig[c];
            settle();
            rd_chk(uart_ctrl_pkg::OFS_IIR, 8'hc4);
        end
        wr_reg(uart_ctrl_pkg::OFS_IIR, 8'h41);
        level <= 5'h01;
        repeat (3) pulse(3'h4);
        settle();
        rd_chk(uart_ctrl_pkg::OFS_IIR, 8'hc1);
        pulse(3'h4);
        settle();
        rd_chk(uart_ctrl_pkg::OFS_IIR, 8'hcc);
        rd_chk(3'h0, 8'ha5);
        settle();
        rd_chk(uart_ctrl_pkg::OFS_IIR, 8'hc1);
    endtask : t_fifo
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        #1 `CHK({dtr_n, rts_n, txd_o, stop_half, irq_oe}, 7'h74)
        rd_chk(uart_ctrl_pkg::OFS_IIR, 8'h01);
        rd_chk(uart_ctrl_pkg::OFS_LCR, 8'h00);
        t_modem();
        t_format();
        // even parity, 8 bits: 0x03 carries parity bit 0
        wr_reg(uart_ctrl_pkg::OFS_LCR, 8'h1b);
        t_receive(1'b0, 1'b1, 2'h0);
        t_receive(1'b1, 1'b1, 2'h2);
        t_receive(1'b0, 1'b0, 2'h1);
        rd_chk(uart_ctrl_pkg::OFS_LSR, 8'h60);
        t_break_divisor_latch_access();
        t_irq();
        t_fifo();
        complete_run();
    end
endmodule : tb_uart_irq_line_modem_ctrl
`default_nettype wire
